// ### pkg/ddc3_cfg_defs.vh
// Offsets, field positions, reset values and decode codes for the
// fourth downconverter channel's rate and oscillator configuration.
// Assumes inclusion by bare name from design files.
`ifndef DDC3_CFG_DEFS_VH
`define DDC3_CFG_DEFS_VH

// ----------------------------------------------------------------
// Register indices (printed offsets) and control register
// ----------------------------------------------------------------
`define IDX_CONTROL 12'h370
`define IDX_RATE_EXT 12'h371
`define IDX_OSC_PROFILE 12'h374
`define IDX_PHASE_UPDATE 12'h375
`define IDX_TUNING_B0 12'h376
`define IDX_TUNING_B1 12'h377

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define CTRL_C2R_BIT 3
`define PRI_HB12 3'h0
`define PRI_HB123 3'h1
`define PRI_HB1234 3'h2
`define PRI_HB1 3'h3
`define PRI_HB1_TB 3'h4
`define PRI_HB12_TB 3'h5
`define PRI_HB123_TB 3'h6
`define PRI_EXT 3'h7
`define SEC_TB_HB1234 4'h0
`define SEC_FB_HB1 4'h2
`define SEC_FB_HB12 4'h3
`define SEC_FB_HB123 4'h4
`define MODE_REG 4'h0
`define MODE_PINS 4'h1
`define MODE_EDGE_A 4'h8
`define MODE_EDGE_B 4'hA

// Filter stage enable bits: hb1 hb2 hb3 hb4 thirdband fifthband
`define STG_HB1 6'h01
`define STG_HB2 6'h02
`define STG_HB3 6'h04
`define STG_HB4 6'h08
`define STG_TB 6'h10
`define STG_FB 6'h20

`endif

// ### tb/ddc3_cfg_props.sv
// Assertions on the downconverter rate and oscillator config ports.
// Assumes a bind onto ddc3_rate_osc_cfg; one clock, sync reset.
`timescale 1ns/1ps
`include "ddc3_cfg_defs.vh"
module ddc3_cfg_props #(
    parameter PROFILE_W = 4
) (
    input wire sys_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire general_pin_a,
    input wire general_pin_b,
    input wire [5:0] stage_enable,
    input wire [5:0] decimation_factor,
    input wire rate_valid,
    input wire real_output_only,
    input wire [PROFILE_W-1:0] active_profile,
    input wire [PROFILE_W-1:0] phase_update_profile,
    input wire [15:0] tuning_word_low
);
    // ----
    // Properties
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire acc = psel && penable;
    wire wr = acc && pwrite && pstrb[0];
    wire mapped = paddr == 16'h0DC0 || paddr == 16'h0DC4 || paddr == 16'h0DD0 ||
        paddr == 16'h0DD4 || paddr == 16'h0DD8 || paddr == 16'h0DDC;
    unmapped_err_a: assert property (pslverr == (acc && !mapped)) else $error("bad pslverr");
    tune_low_a: assert property (wr && paddr == 16'h0DD8 |=> ##1
        tuning_word_low[7:0] == $past(pwdata[7:0], 2)) else $error("tuning low byte");
    tune_high_a: assert property (wr && paddr == 16'h0DDC |=> ##1
        tuning_word_low[15:8] == $past(pwdata[7:0], 2)) else $error("tuning high byte");
    phase_index_a: assert property (wr && paddr == 16'h0DD4 |=> ##1
        phase_update_profile == $past(pwdata[3:0], 2)) else $error("phase index");
    real_only_a: assert property (wr && paddr == 16'h0DC0 |=> ##1
        real_output_only == $past(pwdata[3], 2)) else $error("real output flag");
    hb1_factor_a: assert property (stage_enable == `STG_HB1 |->
        decimation_factor == (real_output_only ? 6'h01 : 6'h02)) else $error("halfband one factor");
    fifth_factor_a: assert property (stage_enable == (`STG_FB | `STG_HB1) |->
        decimation_factor == (real_output_only ? 6'h05 : 6'h0A)) else $error("fifthband factor");
    invalid_rate_a: assert property (!rate_valid |-> decimation_factor == 6'h00) else $error("invalid rate");
    rsvd_read_a: assert property (acc && !pwrite && paddr == 16'h0DC4 |->
        prdata[3:0] == 4'h0) else $error("reserved bits set");
endmodule // ddc3_cfg_props

// ### tb/ddc3_rate_osc_cfg_tb.sv
// Bench for the downconverter rate and oscillator config registers.
// Drives APB and the general pins itself; no far-side model.
`timescale 1ns/1ps
`include "ddc3_cfg_defs.vh"
module ddc3_rate_osc_cfg_tb;
    logic sys_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic general_pin_a = 1'h0, general_pin_b = 1'h0, pready, pslverr, rate_valid, real_output_only;
    logic [3:0] pstrb = 4'hF, active_profile, phase_update_profile;
    logic [5:0] stage_enable, decimation_factor;
    logic [15:0] paddr = 16'h0000, tuning_word_low;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    int miscompares = 0, total_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    ddc3_rate_osc_cfg dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .general_pin_a(general_pin_a), .general_pin_b(general_pin_b), .stage_enable(stage_enable),
        .decimation_factor(decimation_factor), .rate_valid(rate_valid), .real_output_only(real_output_only),
        .active_profile(active_profile), .phase_update_profile(phase_update_profile),
        .tuning_word_low(tuning_word_low));
    // ----
    // Tasks
    // ----
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task xfer(input logic w, input logic [11:0] i, input logic [7:0] d, input logic [3:0] s = 4'hF);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        while (pready !== 1'h1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Pins pass a two-flop sync, so hold each level well past it
    task pins(input logic [1:0] v);
        @(posedge sys_clk);
        {general_pin_b, general_pin_a} <= v;
        settle(8);
    endtask
    task t_reset;
        logic [11:0] ix[6] = '{`IDX_CONTROL, `IDX_RATE_EXT, `IDX_OSC_PROFILE, `IDX_PHASE_UPDATE,
            `IDX_TUNING_B0, `IDX_TUNING_B1};
        settle(2);
        chk(stage_enable, `STG_HB1 | `STG_HB2);
        chk(decimation_factor, 6'h04);
        chk(tuning_word_low, 16'h0000);
        foreach (ix[k]) begin
            xfer(1'h0, ix[k], 8'h00);
            chk(rd, 32'h0);
        end
        $display("reset test done");
    endtask
    task t_rate;
        logic [5:0] st[8] = '{6'h03, 6'h07, 6'h0F, 6'h01, 6'h11, 6'h13, 6'h17, 6'h1F};
        logic [5:0] fc[8] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0C, 6'h18, 6'h30};
        logic [7:0] ex[6] = '{8'h00, 8'h20, 8'h30, 8'h40, 8'h10, 8'h00};
        logic [5:0] sx[6] = '{6'h1F, 6'h21, 6'h23, 6'h27, 6'h00, 6'h1F};
        logic [5:0] fx[6] = '{6'h30, 6'h0A, 6'h14, 6'h28, 6'h00, 6'h30};
        logic [5:0] vx = 6'h2F;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 8; k++) begin
                xfer(1'h1, `IDX_CONTROL, {4'h0, c[0], k[2:0]});
                settle(3);
                chk(stage_enable, st[k]);
                chk(decimation_factor, fc[k] >> c);
                chk(real_output_only, c[0]);
            end
            for (int j = 0; j < 6; j++) begin
                xfer(1'h1, `IDX_RATE_EXT, ex[j]);
                settle(3);
                chk(rate_valid, vx[j]);
                chk(decimation_factor, fx[j] >> c);
                if (vx[j]) chk(stage_enable, sx[j]);
            end
        end
        xfer(1'h1, `IDX_CONTROL, 8'h00);
        xfer(1'h1, `IDX_RATE_EXT, 8'h20);
        settle(3);
        chk(stage_enable, 6'h03);
        xfer(1'h1, `IDX_RATE_EXT, 8'hFF);
        xfer(1'h0, `IDX_RATE_EXT, 8'h00);
        chk(rd, 32'hF0);
        $display("rate test done");
    endtask
    task t_regs;
        xfer(1'h1, `IDX_TUNING_B1, 8'h5A);
        xfer(1'h1, `IDX_TUNING_B0, 8'hA5);
        xfer(1'h1, `IDX_TUNING_B0, 8'h11, 4'h0);
        settle(3);
        chk(tuning_word_low, 16'h5AA5);
        xfer(1'h0, `IDX_TUNING_B1, 8'h00);
        chk(rd, 32'h5A);
        for (int k = 0; k < 4; k++) begin
            xfer(1'h1, `IDX_PHASE_UPDATE, {4'hF, k[3:0]});
            settle(3);
            chk(phase_update_profile, k[3:0]);
        end
        xfer(1'h0, `IDX_PHASE_UPDATE, 8'h00);
        chk(rd, 32'h03);
        xfer(1'h0, 12'h372, 8'h00);
        chk(rd, 32'h0);
        chk(err, 1'h1);
        $display("register test done");
    endtask
    task t_prof;
        for (int n = 0; n < 16; n += 5) begin
            xfer(1'h1, `IDX_OSC_PROFILE, n[7:0]);
            settle(3);
            chk(active_profile, n[3:0]);
        end
        xfer(1'h1, `IDX_OSC_PROFILE, 8'h1F);
        for (int k = 0; k < 4; k++) begin
            pins(k[1:0]);
            chk(active_profile, k[3:0]);
        end
        pins(2'h0);
        xfer(1'h1, `IDX_OSC_PROFILE, 8'h82);
        for (int k = 1; k < 4; k++) begin
            pins(2'h1);
            pins(2'h0);
            chk(active_profile, k % 3);
        end
        xfer(1'h1, `IDX_OSC_PROFILE, 8'hA2);
        pins(2'h1);
        pins(2'h0);
        chk(active_profile, 4'h0);
        pins(2'h2);
        pins(2'h0);
        chk(active_profile, 4'h1);
        xfer(1'h1, `IDX_OSC_PROFILE, 8'h36);
        settle(3);
        chk(active_profile, 4'h6);
        $display("profile test done");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'h0;
        t_reset;
        t_rate;
        t_regs;
        t_prof;
        close_out;
    end
    // Whole run is a few hundred cycles
    initial begin
        #500us;
        miscompares++;
        close_out;
    end
endmodule // ddc3_rate_osc_cfg_tb
bind ddc3_rate_osc_cfg ddc3_cfg_props #(.PROFILE_W(PROFILE_W)) props_u (.sys_clk(sys_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .general_pin_a(general_pin_a),
    .general_pin_b(general_pin_b), .stage_enable(stage_enable), .decimation_factor(decimation_factor),
    .rate_valid(rate_valid), .real_output_only(real_output_only), .active_profile(active_profile),
    .phase_update_profile(phase_update_profile), .tuning_word_low(tuning_word_low));

// ### verilog/ddc3_rate_osc_cfg.v
// Configuration registers of the fourth downconverter channel: decimation
// rate decode, oscillator profile selection and low tuning word bytes.
// Assumes an APB master on sys_clk; general pins are asynchronous.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ddc3_cfg_defs.vh"

module ddc3_rate_osc_cfg #(
    parameter PROFILE_W = 4
) (
    input wire sys_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire general_pin_a,
    input wire general_pin_b,
    output reg [5:0] stage_enable,
    output reg [5:0] decimation_factor,
    output reg rate_valid,
    output reg real_output_only,
    output reg [PROFILE_W-1:0] active_profile,
    output reg [PROFILE_W-1:0] phase_update_profile,
    output reg [15:0] tuning_word_low
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [7:0] control_q;
    reg [3:0] sec_rate_q;
    reg [7:0] osc_profile_q;
    reg [3:0] phase_index_q;
    reg [7:0] tuning_b0_q;
    reg [7:0] tuning_b1_q;
    reg [PROFILE_W-1:0] edge_count_q;
    reg [PROFILE_W-1:0] edge_count_d;

    wire access = psel & penable;
    wire wr_en = access & pwrite & pstrb[0];
    wire [11:0] index = paddr[13:2];
    wire addr_ok = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);

    // Index decode, shared by write selects and the error flag
    function hit;
        input [11:0] idx;
        input [11:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // ------------------------------------------------------------
    // Register selects; misaligned or high addresses select nothing
    // ------------------------------------------------------------
    wire sel_control = addr_ok & hit(index, `IDX_CONTROL);
    wire sel_rate_ext = addr_ok & hit(index, `IDX_RATE_EXT);
    wire sel_osc_profile = addr_ok & hit(index, `IDX_OSC_PROFILE);
    wire sel_phase_update = addr_ok & hit(index, `IDX_PHASE_UPDATE);
    wire sel_tuning_b0 = addr_ok & hit(index, `IDX_TUNING_B0);
    wire sel_tuning_b1 = addr_ok & hit(index, `IDX_TUNING_B1);

    wire mapped = sel_control | sel_rate_ext | sel_osc_profile | sel_phase_update |
        sel_tuning_b0 | sel_tuning_b1;

    // Zero-wait slave; unmapped accesses flag an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Byte lane 0 carries every register; other lanes are ignored
    always @(posedge sys_clk) begin
        if (reset) begin
            control_q <= `RST_BYTE;
        end else if (wr_en && sel_control) begin
            control_q <= pwdata[7:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            sec_rate_q <= 4'h0;
        end else if (wr_en && sel_rate_ext) begin
            sec_rate_q <= pwdata[7:4];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            osc_profile_q <= `RST_BYTE;
        end else if (wr_en && sel_osc_profile) begin
            osc_profile_q <= pwdata[7:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            phase_index_q <= 4'h0;
        end else if (wr_en && sel_phase_update) begin
            phase_index_q <= pwdata[3:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            tuning_b0_q <= `RST_BYTE;
        end else if (wr_en && sel_tuning_b0) begin
            tuning_b0_q <= pwdata[7:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            tuning_b1_q <= `RST_BYTE;
        end else if (wr_en && sel_tuning_b1) begin
            tuning_b1_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Loaded in the setup phase so the word stands through the access phase
    always @(posedge sys_clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (!addr_ok) begin
                prdata <= 32'h00000000;
            end else begin
                case (index)
                    `IDX_CONTROL: prdata <= {24'h000000, control_q};
                    `IDX_RATE_EXT: prdata <= {24'h000000, sec_rate_q, 4'h0};
                    `IDX_OSC_PROFILE: prdata <= {24'h000000, osc_profile_q};
                    `IDX_PHASE_UPDATE: prdata <= {28'h0000000, phase_index_q};
                    `IDX_TUNING_B0: prdata <= {24'h000000, tuning_b0_q};
                    `IDX_TUNING_B1: prdata <= {24'h000000, tuning_b1_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    wire [1:0] pin_in = {general_pin_b, general_pin_a};
    wire [1:0] pin_sync;
    wire [1:0] pin_rise;
    genvar g;

    // Reset level matches the idle-low pins, so no false edge follows reset
    generate
        for (g = 0; g < 2; g = g + 1) begin : pin_sync_g
            reg stage1_q;
            reg stage2_q;
            reg last_q;

            always @(posedge sys_clk) begin
                if (reset) begin
                    stage1_q <= 1'b0;
                    stage2_q <= 1'b0;
                    last_q <= 1'b0;
                end else begin
                    stage1_q <= pin_in[g];
                    stage2_q <= stage1_q;
                    last_q <= stage2_q;
                end
            end

            assign pin_sync[g] = stage2_q;
            assign pin_rise[g] = stage2_q & ~last_q;
        end
    endgenerate

    wire pin_a_sync = pin_sync[0];
    wire pin_b_sync = pin_sync[1];
    wire pin_a_rise = pin_rise[0];
    wire pin_b_rise = pin_rise[1];
    wire [3:0] sel_mode = osc_profile_q[7:4];
    wire [PROFILE_W-1:0] wrap_at = osc_profile_q[PROFILE_W-1:0];

    // ------------------------------------------------------------
    // Edge-driven profile counter
    // ------------------------------------------------------------
    wire step_a = (sel_mode == `MODE_EDGE_A) & pin_a_rise;
    wire step_b = (sel_mode == `MODE_EDGE_B) & pin_b_rise;
    // Compare with >= so a nibble lowered below the count still wraps
    wire at_wrap = (edge_count_q >= wrap_at);

    always @* begin
        edge_count_d = edge_count_q;
        if (step_a | step_b) begin
            if (at_wrap) begin
                edge_count_d = {PROFILE_W{1'b0}};
            end else begin
                edge_count_d = edge_count_q + 1'b1;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            edge_count_q <= {PROFILE_W{1'b0}};
        end else begin
            edge_count_q <= edge_count_d;
        end
    end

    // ------------------------------------------------------------
    // Profile outputs
    // ------------------------------------------------------------
    // Undefined select modes fall back to the register field
    always @(posedge sys_clk) begin
        if (reset) begin
            active_profile <= {PROFILE_W{1'b0}};
        end else begin
            case (sel_mode)
                `MODE_REG: active_profile <= osc_profile_q[PROFILE_W-1:0];
                `MODE_PINS: active_profile <= {2'b0, pin_b_sync, pin_a_sync};
                `MODE_EDGE_A: active_profile <= edge_count_q;
                `MODE_EDGE_B: active_profile <= edge_count_q;
                default: active_profile <= osc_profile_q[PROFILE_W-1:0];
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            phase_update_profile <= {PROFILE_W{1'b0}};
        end else begin
            phase_update_profile <= phase_index_q;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            tuning_word_low <= 16'h0000;
        end else begin
            tuning_word_low <= {tuning_b1_q, tuning_b0_q};
        end
    end

    // ------------------------------------------------------------
    // Decimation decode; factor shown is the complex one, halved for real
    // ------------------------------------------------------------
    reg [5:0] stages_d;
    reg [5:0] cplx_factor_d;
    reg valid_d;
    wire c2r = control_q[`CTRL_C2R_BIT];

    always @* begin
        stages_d = 6'h00;
        cplx_factor_d = 6'd0;
        valid_d = 1'b1;
        case (control_q[2:0])
            `PRI_HB12: begin
                stages_d = `STG_HB1 | `STG_HB2;
                cplx_factor_d = 6'd4;
            end
            `PRI_HB123: begin
                stages_d = `STG_HB1 | `STG_HB2 | `STG_HB3;
                cplx_factor_d = 6'd8;
            end
            `PRI_HB1234: begin
                stages_d = `STG_HB1 | `STG_HB2 | `STG_HB3 | `STG_HB4;
                cplx_factor_d = 6'd16;
            end
            `PRI_HB1: begin
                stages_d = `STG_HB1;
                cplx_factor_d = 6'd2;
            end
            `PRI_HB1_TB: begin
                stages_d = `STG_HB1 | `STG_TB;
                cplx_factor_d = 6'd6;
            end
            `PRI_HB12_TB: begin
                stages_d = `STG_HB1 | `STG_HB2 | `STG_TB;
                cplx_factor_d = 6'd12;
            end
            `PRI_HB123_TB: begin
                stages_d = `STG_HB1 | `STG_HB2 | `STG_HB3 | `STG_TB;
                cplx_factor_d = 6'd24;
            end
            `PRI_EXT: begin
                case (sec_rate_q)
                    `SEC_TB_HB1234: begin
                        stages_d = `STG_TB | `STG_HB1 | `STG_HB2 | `STG_HB3 | `STG_HB4;
                        cplx_factor_d = 6'd48;
                    end
                    `SEC_FB_HB1: begin
                        stages_d = `STG_FB | `STG_HB1;
                        cplx_factor_d = 6'd10;
                    end
                    `SEC_FB_HB12: begin
                        stages_d = `STG_FB | `STG_HB1 | `STG_HB2;
                        cplx_factor_d = 6'd20;
                    end
                    `SEC_FB_HB123: begin
                        stages_d = `STG_FB | `STG_HB1 | `STG_HB2 | `STG_HB3;
                        cplx_factor_d = 6'd40;
                    end
                    default: begin
                        valid_d = 1'b0;
                    end
                endcase
            end
            default: begin
                valid_d = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            stage_enable <= 6'h00;
        end else begin
            stage_enable <= stages_d;
        end
    end

    // Real output halves the complex factor; an invalid code shows zero
    always @(posedge sys_clk) begin
        if (reset) begin
            decimation_factor <= 6'h00;
        end else begin
            decimation_factor <= c2r ? {1'b0, cplx_factor_d[5:1]} : cplx_factor_d;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            rate_valid <= 1'b0;
        end else begin
            rate_valid <= valid_d;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            real_output_only <= 1'b0;
        end else begin
            real_output_only <= c2r;
        end
    end

endmodule // ddc3_rate_osc_cfg
